// file: include/rrce_pkg.sv
package rrce_pkg;

  // Quarter-cycle phase codes within one instruction cycle.
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // Opcode patterns: return keeps its fast bit in bit 0.
  localparam logic [14:0] OPC_RETURN = 15'h0009;
  // Rotate-left-through-carry keeps d in bit 9 and a in bit 8.
  localparam logic [5:0] OPC_ROTATE = 6'h0D;
  localparam int RET_FAST_BIT = 0;
  localparam int ROT_DEST_BIT = 9;
  localparam int ROT_BANK_BIT = 8;

  // Flag positions inside the status register.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 4;

  // Program counter advance per executed one-word instruction.
  localparam logic [20:0] PC_STEP = 21'h000002;

  // Upper address nibble used for the high half of the access bank.
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

  // Register port word indices.
  localparam logic [3:0] REG_WORKING = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h1;
  localparam logic [3:0] REG_BANK = 4'h2;
  localparam logic [3:0] REG_SH_WORKING = 4'h3;
  localparam logic [3:0] REG_SH_FLAGS = 4'h4;
  localparam logic [3:0] REG_SH_BANK = 4'h5;
  localparam logic [3:0] REG_PC = 4'h6;
  localparam logic [3:0] REG_STACK = 4'h7;
  localparam logic [3:0] REG_STACK_STAT = 4'h8;
  localparam logic [3:0] REG_PC_HIGH = 4'h9;
  localparam logic [3:0] REG_PC_UPPER = 4'hA;

  // Bit positions in the stack status register.
  localparam int STK_UNF_BIT = 8;
  localparam int STK_OVF_BIT = 9;

  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [20:0] RST_PC = 21'h000000;
  localparam logic [4:0] RST_UPPER = 5'h00;
  localparam logic [31:0] RST_RDATA = 32'h00000000;
  localparam logic [11:0] RST_DADDR = 12'h000;

  // Kind of instruction held for the current cycle.
  typedef enum logic [1:0] {
    OP_NONE,
    OP_RETURN,
    OP_ROTATE
  } rrce_op_e;

  // Classify an instruction word; anything else is no work for us.
  function automatic rrce_op_e rrce_decode(input logic [15:0] word);
    rrce_op_e op;
    op = OP_NONE;
    if (word[15:1] == OPC_RETURN) begin
      op = OP_RETURN;
    end else if (word[15:10] == OPC_ROTATE) begin
      op = OP_ROTATE;
    end
    return op;
  endfunction

endpackage

// file: src/rrce_stack_mem.sv
`timescale 1ns/1ps
// Return stack storage with one write port and a registered read port.
module rrce_stack_mem #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 31,
  parameter int AW = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  // The array itself has no reset; entries are valid only once pushed.
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write port.
  always_ff @(posedge clk_in) begin
    if (wr_en_in && (int'(wr_addr_in) < DEPTH)) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Read data come from a register, so they trail the address by one edge.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else if (int'(rd_addr_in) < DEPTH) begin
      rd_data_out <= mem_q[rd_addr_in];
    end else begin
      rd_data_out <= '0;
    end
  end

endmodule

// file: src/rrce_core.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Executes subroutine return and rotate-left-through-carry on a core
// whose instruction cycle is split into four quarter-cycles of one clock.
module rrce_core import rrce_pkg::*; #(
  parameter int STACK_DEPTH = 31,
  parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] instr_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [7:0] dmem_rdata_in,
  output logic [11:0] dmem_addr_out,
  output logic dmem_rd_out,
  output logic dmem_we_out,
  output logic [7:0] dmem_wdata_out,
  output logic [1:0] phase_out,
  output logic flush_out,
  output logic [20:0] pc_out,
  output logic [7:0] working_out,
  output logic [7:0] flags_out
);

  // Stack pointer width: it counts from zero up to a full stack.
  localparam int SPW = $clog2(STACK_DEPTH + 1);
  localparam logic [SPW-1:0] SP_FULL = SPW'(STACK_DEPTH);
  localparam logic [SPW-1:0] SP_ONE = SPW'(1);

  logic [1:0] phase_q; // Current quarter-cycle.
  rrce_op_e op_q; // Instruction being executed.
  logic [15:0] instr_q; // Its word, for operand fields.
  logic flush_q; // High through the flushed cycle.
  logic [7:0] w_q; // Working register.
  logic [7:0] flags_q; // Status flags.
  logic [3:0] bank_select_reg_q; // Bank-select register.
  logic [7:0] shadow_working_reg_q; // Shadow copy of working.
  logic [7:0] shadow_flags_reg_q; // Shadow copy of flags.
  logic [3:0] shadow_bank_select_q; // Shadow copy of bank select.
  logic [20:0] pc_q; // Program counter.
  logic [7:0] pc_high_latch_q; // High latch, never touched by return.
  logic [4:0] pc_upper_latch_q; // Upper latch, never touched by return.
  logic [SPW-1:0] sp_q; // Number of entries on the stack.
  logic unf_q; // Sticky: popped an empty stack.
  logic ovf_q; // Sticky: pushed a full stack.
  logic [11:0] daddr_q; // Data address driven to the file.
  logic drd_q; // Data read strobe.
  logic dwe_q; // Data write strobe.
  logic [7:0] dwdata_q; // Data write value.
  logic [31:0] rdata_q; // Register port read data.

  logic [20:0] stack_top_value; // Top entry, from the stack memory.
  logic [SPW-1:0] top_index; // Index of the top entry.
  logic pop_now; // The return pops on this edge.
  logic push_now; // Software pushes on this edge.
  logic fast_restore; // The return also restores shadows.
  logic rot_now; // Rotate result is formed on this edge.
  logic [7:0] rot_result; // Rotated byte.
  logic rot_carry; // Carry out of the rotation.
  logic rot_to_working; // Destination is the working register.
  rrce_op_e fetch_op; // Class of the word on instr_in.

  // Form the full data address from the file field and the bank bit.
  function automatic logic [11:0] data_addr(input logic [15:0] word,
                                            input logic [3:0] bank);
    logic [11:0] addr;
    addr = {ACCESS_LOW_BANK, word[7:0]};
    if (word[ROT_BANK_BIT]) begin
      addr = {bank, word[7:0]};
    end else if (word[7:0] >= ACCESS_SPLIT) begin
      addr = {ACCESS_HIGH_BANK, word[7:0]};
    end
    return addr;
  endfunction

  // Software register writes, decoded once and shared by every process.
  function automatic logic sw_wr(input logic [3:0] idx);
    return reg_wr_in && (reg_addr_in == idx);
  endfunction

  assign fetch_op = rrce_decode(instr_in);
  assign top_index = sp_q - SP_ONE;
  // The pop falls in the last quarter of the return's first cycle.
  assign pop_now = (phase_q == PH_Q4) && (op_q == OP_RETURN);
  assign fast_restore = pop_now && instr_q[RET_FAST_BIT];
  // A push that meets a pop is dropped; both cannot share the pointer.
  assign push_now = sw_wr(REG_STACK) && !pop_now;
  assign rot_now = (phase_q == PH_Q3) && (op_q == OP_ROTATE);
  assign rot_to_working = !instr_q[ROT_DEST_BIT];
  // Each bit moves one place up, old carry enters bit 0.
  assign rot_result = {dmem_rdata_in[6:0], flags_q[FLAG_C]};
  assign rot_carry = dmem_rdata_in[7];

  // The stack storage lives in its own module with registered read data.
  rrce_stack_mem #(
    .WIDTH(21),
    .DEPTH(STACK_DEPTH),
    .AW(SPW)
  ) u_stack (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_en_in(push_now && (sp_q != SP_FULL)),
    .wr_addr_in(sp_q),
    .wr_data_in(reg_wdata_in[20:0]),
    .rd_addr_in(top_index),
    .rd_data_out(stack_top_value)
  );

  // Quarter-cycle counter; it free-runs so every instruction cycle takes four clocks.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Decode in the first quarter; a flushed cycle decodes nothing.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      op_q <= OP_NONE;
      instr_q <= 16'h0000;
    end else if (phase_q == PH_Q1) begin
      instr_q <= instr_in;
      if (flush_q) begin
        op_q <= OP_NONE;
      end else begin
        op_q <= fetch_op;
      end
    end
  end

  // The cycle after a return is a no-operation so the new fetch can settle.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flush_q <= 1'h0;
    end else if (phase_q == PH_Q4) begin
      flush_q <= (op_q == OP_RETURN);
    end
  end

  // Program counter: a return loads the top entry; an unflushed cycle steps by one word; else software may write it.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pc_q <= RST_PC;
    end else if (pop_now) begin
      if (sp_q == '0) begin
        pc_q <= RST_PC; // An empty stack yields address zero.
      end else begin
        pc_q <= stack_top_value;
      end
    end else if ((phase_q == PH_Q4) && !flush_q) begin
      pc_q <= pc_q + PC_STEP;
    end else if (sw_wr(REG_PC)) begin
      pc_q <= reg_wdata_in[20:0];
    end
  end

  // High program-counter latches are plain software registers; the return
  // deliberately has no path into them.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pc_high_latch_q <= RST_BYTE;
      pc_upper_latch_q <= RST_UPPER;
    end else begin
      if (sw_wr(REG_PC_HIGH)) begin
        pc_high_latch_q <= reg_wdata_in[7:0];
      end
      if (sw_wr(REG_PC_UPPER)) begin
        pc_upper_latch_q <= reg_wdata_in[4:0];
      end
    end
  end

  // Stack pointer and its sticky error flags; a hardware set beats a clear.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sp_q <= '0;
      unf_q <= 1'h0;
      ovf_q <= 1'h0;
    end else begin
      if (pop_now) begin
        if (sp_q != '0) begin
          sp_q <= sp_q - SP_ONE;
        end
      end else if (push_now && (sp_q != SP_FULL)) begin
        sp_q <= sp_q + SP_ONE;
      end
      if (pop_now && (sp_q == '0)) begin
        unf_q <= 1'h1;
      end else if (sw_wr(REG_STACK_STAT) && reg_wdata_in[STK_UNF_BIT]) begin
        unf_q <= 1'h0;
      end
      if (push_now && (sp_q == SP_FULL)) begin
        ovf_q <= 1'h1;
      end else if (sw_wr(REG_STACK_STAT) && reg_wdata_in[STK_OVF_BIT]) begin
        ovf_q <= 1'h0;
      end
    end
  end

  // Working register: shadow restore, rotate result, or software write.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      w_q <= RST_BYTE;
    end else if (fast_restore) begin
      w_q <= shadow_working_reg_q;
    end else if (rot_now && rot_to_working) begin
      w_q <= rot_result;
    end else if (sw_wr(REG_WORKING)) begin
      w_q <= reg_wdata_in[7:0];
    end
  end

  // Flags: a plain return never reaches here, only its fast form does.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_q <= RST_BYTE;
    end else if (fast_restore) begin
      flags_q <= shadow_flags_reg_q;
    end else if (rot_now) begin
      flags_q[FLAG_C] <= rot_carry;
      flags_q[FLAG_N] <= rot_result[7];
      flags_q[FLAG_Z] <= (rot_result == 8'h00);
    end else if (sw_wr(REG_FLAGS)) begin
      flags_q <= reg_wdata_in[7:0];
    end
  end

  // Bank select; a return with the fast bit clear leaves it alone.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bank_select_reg_q <= RST_BANK;
    end else if (fast_restore) begin
      bank_select_reg_q <= shadow_bank_select_q;
    end else if (sw_wr(REG_BANK)) begin
      bank_select_reg_q <= reg_wdata_in[3:0];
    end
  end

  // Shadow copies are loaded by software only in this block.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shadow_working_reg_q <= RST_BYTE;
      shadow_flags_reg_q <= RST_BYTE;
      shadow_bank_select_q <= RST_BANK;
    end else begin
      if (sw_wr(REG_SH_WORKING)) begin
        shadow_working_reg_q <= reg_wdata_in[7:0];
      end
      if (sw_wr(REG_SH_FLAGS)) begin
        shadow_flags_reg_q <= reg_wdata_in[7:0];
      end
      if (sw_wr(REG_SH_BANK)) begin
        shadow_bank_select_q <= reg_wdata_in[3:0];
      end
    end
  end

  // Data file access: address and read strobe in the second quarter, data
  // back in the third, write strobe in the fourth when the file is the target.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      daddr_q <= RST_DADDR;
      drd_q <= 1'h0;
      dwe_q <= 1'h0;
      dwdata_q <= RST_BYTE;
    end else begin
      drd_q <= 1'h0;
      dwe_q <= 1'h0;
      if ((phase_q == PH_Q1) && !flush_q && (fetch_op == OP_ROTATE)) begin
        daddr_q <= data_addr(instr_in, bank_select_reg_q);
        drd_q <= 1'h1;
      end
      if (rot_now && !rot_to_working) begin
        dwe_q <= 1'h1;
        dwdata_q <= rot_result;
      end
    end
  end

  // Register port read: data stand for exactly one cycle; unmapped reads zero.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= RST_RDATA;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_WORKING: rdata_q <= {24'h000000, w_q};
        REG_FLAGS: rdata_q <= {24'h000000, flags_q};
        REG_BANK: rdata_q <= {28'h0000000, bank_select_reg_q};
        REG_SH_WORKING: rdata_q <= {24'h000000, shadow_working_reg_q};
        REG_SH_FLAGS: rdata_q <= {24'h000000, shadow_flags_reg_q};
        REG_SH_BANK: rdata_q <= {28'h0000000, shadow_bank_select_q};
        REG_PC: rdata_q <= {11'h0, pc_q};
        REG_STACK: rdata_q <= (sp_q == '0) ? RST_RDATA : {11'h0, stack_top_value};
        REG_STACK_STAT: rdata_q <= {22'h0, ovf_q, unf_q, 8'(sp_q)};
        REG_PC_HIGH: rdata_q <= {24'h000000, pc_high_latch_q};
        REG_PC_UPPER: rdata_q <= {27'h0, pc_upper_latch_q};
        default: rdata_q <= RST_RDATA;
      endcase
    end else begin
      rdata_q <= RST_RDATA;
    end
  end

  // Outputs all come straight from registers.
  assign reg_rdata_out = rdata_q;
  assign dmem_addr_out = daddr_q;
  assign dmem_rd_out = drd_q;
  assign dmem_we_out = dwe_q;
  assign dmem_wdata_out = dwdata_q;
  assign phase_out = phase_q;
  assign flush_out = flush_q;
  assign pc_out = pc_q;
  assign working_out = w_q;
  assign flags_out = flags_q;

endmodule

// file: test/rrce_core_asserts.sv
`timescale 1ns/1ps
// Watches data-file strobes, rotate results and the flush window at the core ports.
module rrce_core_checker import rrce_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] dmem_rdata_in,
  input wire logic [11:0] dmem_addr_out,
  input wire logic dmem_rd_out,
  input wire logic dmem_we_out,
  input wire logic [7:0] dmem_wdata_out,
  input wire logic [1:0] phase_out,
  input wire logic flush_out,
  input wire logic [20:0] pc_out,
  input wire logic [7:0] working_out,
  input wire logic [7:0] flags_out
);
  // One clock domain, so clock and reset are given once for all properties.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_read_in_q2: assert property (dmem_rd_out |-> phase_out == PH_Q2)
    else $error("data read strobe outside the second quarter");
  a_write_after_read: assert property (dmem_we_out |-> phase_out == PH_Q4 &&
    $past(dmem_rd_out, 2) && dmem_addr_out == $past(dmem_addr_out, 2))
    else $error("data write not tied to the read of the same byte");
  a_rotate_value: assert property (dmem_we_out |->
    dmem_wdata_out == {$past(dmem_rdata_in[6:0]), $past(flags_out[FLAG_C])})
    else $error("rotated byte wrong");
  a_carry_out: assert property (dmem_we_out |->
    flags_out[FLAG_C] == $past(dmem_rdata_in[7]))
    else $error("carry not taken from the old top bit");
  a_flags_nz: assert property (dmem_we_out |-> flags_out[FLAG_N] == dmem_wdata_out[7] &&
    flags_out[FLAG_Z] == (dmem_wdata_out == 8'h00))
    else $error("negative or zero flag wrong after rotate");
  a_mem_dest_keeps_w: assert property (dmem_we_out |-> $stable(working_out))
    else $error("working register changed by a rotate into memory");
  a_flush_length: assert property ($rose(flush_out) |->
    phase_out == PH_Q1 ##0 flush_out[*4] ##1 !flush_out)
    else $error("flushed cycle is not exactly one instruction cycle");
  a_flush_pc_hold: assert property (flush_out |=> pc_out == $past(pc_out))
    else $error("program counter moved during the flushed cycle");

  // Main scenarios: write-back rotate, working-register rotate, return.
  c_mem_write: cover property (dmem_we_out);
  c_w_dest: cover property (dmem_rd_out ##2 !dmem_we_out);
  c_return: cover property ($rose(flush_out));
endmodule

bind rrce_core rrce_core_checker u_rrce_core_checker (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .dmem_rdata_in(dmem_rdata_in),
  .dmem_addr_out(dmem_addr_out),
  .dmem_rd_out(dmem_rd_out),
  .dmem_we_out(dmem_we_out),
  .dmem_wdata_out(dmem_wdata_out),
  .phase_out(phase_out),
  .flush_out(flush_out),
  .pc_out(pc_out),
  .working_out(working_out),
  .flags_out(flags_out)
);

// file: test/rrce_dmem_model.sv
`timescale 1ns/1ps
// Behavioural data register file on the far side of the core.
module rrce_dmem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [11:0] addr_in,
  input wire logic rd_in,
  input wire logic we_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  // Byte storage; the bench preloads bytes only between instructions.
  logic [7:0] mem [0:4095];

  // Read data stand only in the cycle after the strobe. Afterwards the bus
  // inverts on every clock, so a sample one cycle late by the core cannot match by luck.
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'hA5;
    end else if (rd_in) begin
      rdata_out <= mem[addr_in];
    end else begin
      rdata_out <= ~rdata_out;
    end
    // Writes land at the edge that ends the strobe cycle.
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule

// file: test/tb_rrce_core.sv
`timescale 1ns/1ps
// Self-checking bench for the return and rotate execution core.
module tb_rrce_core;
  import rrce_pkg::*;
  // One rotate case: operands beside the address and result they should give.
  typedef struct {
    logic d;
    logic a;
    logic [7:0] f;
    logic [3:0] bank;
    logic [7:0] data;
    logic cin;
    logic [11:0] addr;
    logic [7:0] res;
  } rrce_row_s;
  // Access split handed to the core; the row addresses assume this value.
  localparam logic [7:0] SPLIT = 8'h80;
  logic clk_in, rst_in, reg_wr_in, reg_rd_in, dmem_rd_out, dmem_we_out, flush_out;
  logic [15:0] instr_in;
  logic [3:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, v;
  logic [7:0] dmem_rdata_in, dmem_wdata_out, working_out, flags_out;
  // Data-file byte at the row's address, read back once the rotate is over.
  logic [7:0] m;
  logic [11:0] dmem_addr_out;
  logic [1:0] phase_out;
  logic [20:0] pc_out;
  int num_errors = 0;
  int checked = 0;
  rrce_row_s r;
  // Both bank modes, both destinations, both split sides and zero results.
  rrce_row_s rows [5] = '{
    '{1'h1, 1'h1, 8'h34, 4'h3, 8'hA5, 1'h0, 12'h334, 8'h4A},
    '{1'h0, 1'h1, 8'h10, 4'h5, 8'h80, 1'h0, 12'h510, 8'h00},
    '{1'h1, 1'h0, 8'h7F, 4'h9, 8'h40, 1'h1, 12'h07F, 8'h81},
    '{1'h0, 1'h0, 8'h80, 4'h2, 8'hFF, 1'h1, 12'hF80, 8'hFF},
    '{1'h1, 1'h0, 8'hFF, 4'hC, 8'h00, 1'h0, 12'hFFF, 8'h00}};

  rrce_core #(.STACK_DEPTH(31), .ACCESS_SPLIT(SPLIT)) u_rrce_core (
    .clk_in(clk_in), .rst_in(rst_in), .instr_in(instr_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .dmem_rdata_in(dmem_rdata_in),
    .dmem_addr_out(dmem_addr_out), .dmem_rd_out(dmem_rd_out), .dmem_we_out(dmem_we_out),
    .dmem_wdata_out(dmem_wdata_out), .phase_out(phase_out), .flush_out(flush_out),
    .pc_out(pc_out), .working_out(working_out), .flags_out(flags_out));

  rrce_dmem_model u_rrce_dmem_model (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(dmem_addr_out), .rd_in(dmem_rd_out), .we_in(dmem_we_out),
    .wdata_in(dmem_wdata_out), .rdata_out(dmem_rdata_in));

  // 20 MHz core clock.
  initial begin
    clk_in = 1'h0;
    forever #25 clk_in = ~clk_in;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares one value with its expectation; unknowns never match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register write strobe.
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask

  // One-cycle read strobe; the data are taken in the following cycle only.
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    @(negedge clk_in);
    d = reg_rdata_out;
  endtask

  // Presents a word in the first quarter of one instruction cycle and returns once that cycle has ended.
  // With keep set the word stays on the bus, which the core must ignore while
  // it flushes; the caller must then issue the next word at once.
  task automatic issue(input logic [15:0] w, input logic keep);
    int n;
    n = 0;
    @(negedge clk_in);
    while (phase_out !== PH_Q4 && n < 8) begin
      @(negedge clk_in);
      n++;
    end
    // A phase counter that never reaches the last quarter counts as a mismatch.
    if (n >= 8) begin
      num_errors++;
      print_verdict();
    end else begin
      @(posedge clk_in);
      instr_in <= w;
      @(posedge clk_in);
      if (!keep) begin
        instr_in <= 16'h0000;
      end
      repeat (3) @(posedge clk_in);
      #1;
    end
  endtask

  initial begin
    rst_in = 1'h1;
    instr_in = 16'h0000;
    reg_addr_in = 4'h0;
    reg_wdata_in = 32'h0;
    reg_wr_in = 1'h0;
    reg_rd_in = 1'h0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'h0;
    #1;
    chk({3'h0, pc_out, working_out}, 32'h0);
    chk({21'h0, flags_out, flush_out, phase_out}, 32'h0);
    // Rotate table: operands set through registers and the data file.
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      reg_wr(REG_BANK, {28'h0, r.bank});
      reg_wr(REG_FLAGS, {31'h0, r.cin});
      reg_wr(REG_WORKING, 32'h000000C3);
      u_rrce_dmem_model.mem[r.addr] = r.data;
      issue({OPC_ROTATE, r.d, r.a, r.f}, 1'h0);
      m = u_rrce_dmem_model.mem[r.addr];
      chk(32'(dmem_addr_out), 32'(r.addr));
      chk(32'(r.d ? m : working_out), 32'(r.res));
      chk(32'(r.d ? working_out : m), 32'(r.d ? 8'hC3 : r.data));
      chk(32'(flags_out), {27'h0, r.res[7], 1'h0, !(|r.res), 1'h0, r.data[7]});
    end
    // Return without and then with the shadow restore.
    reg_wr(REG_SH_WORKING, 32'h00000011);
    reg_wr(REG_SH_FLAGS, 32'h00000014);
    reg_wr(REG_SH_BANK, 32'h00000006);
    reg_wr(REG_WORKING, 32'h00000022);
    reg_wr(REG_FLAGS, 32'h00000001);
    reg_wr(REG_BANK, 32'h00000003);
    reg_wr(REG_PC_HIGH, 32'h0000005C);
    reg_wr(REG_PC_UPPER, 32'h00000015);
    reg_wr(REG_STACK, 32'h00000A00);
    reg_wr(REG_STACK, 32'h00001234);
    issue({OPC_RETURN, 1'h0}, 1'h0);
    chk(32'(pc_out), 32'h00001234);
    chk(32'(flush_out), 32'h1);
    chk(32'({working_out, flags_out}), 32'h00002201);
    reg_rd(REG_BANK, v);
    chk(v, 32'h00000003);
    issue({OPC_RETURN, 1'h1}, 1'h0);
    chk(32'(pc_out), 32'h00000A00);
    chk(32'({working_out, flags_out}), 32'h00001114);
    reg_rd(REG_BANK, v);
    chk(v, 32'h00000006);
    reg_rd(REG_PC_HIGH, v);
    chk(v, 32'h0000005C);
    // Neither return may reach the upper latch either.
    reg_rd(REG_PC_UPPER, v);
    chk(v, 32'h00000015);
    // Return word held through the flush must pop only once.
    reg_wr(REG_STACK, 32'h00000100);
    issue({OPC_RETURN, 1'h0}, 1'h1);
    issue(16'h0000, 1'h0);
    chk(32'(pc_out), 32'h00000100 + 32'(PC_STEP));
    reg_rd(REG_STACK_STAT, v);
    chk(v, 32'h00000000);
    // Return on an empty stack.
    issue({OPC_RETURN, 1'h0}, 1'h0);
    chk(32'(pc_out), 32'h00000000);
    reg_rd(REG_STACK_STAT, v);
    chk(32'(v[STK_UNF_BIT]), 32'h1);
    print_verdict();
  end
endmodule
